//--- pkg/tmr_pkg.sv
// Shared constants and types for the three-channel prescaled timer.
// Assumes a 32-bit byte address bus; registers are word aligned.
package tmr_pkg;

    // Data width of every timer register
    localparam int DW = 16;

    // Register byte addresses
    localparam logic [31:0] ADR_PRESC    = 32'hffffe900;
    localparam logic [31:0] ADR_RSVD     = 32'hffffe904;
    localparam logic [31:0] ADR_C0_CNT   = 32'hffffe910;
    localparam logic [31:0] ADR_C0_MATCH = 32'hffffe914;
    localparam logic [31:0] ADR_C0_PW    = 32'hffffe918;
    localparam logic [31:0] ADR_C0_CTL   = 32'hffffe91c;
    localparam logic [31:0] ADR_C1_CNT   = 32'hffffe920;
    localparam logic [31:0] ADR_C1_MATCH = 32'hffffe924;
    localparam logic [31:0] ADR_C1_CTL   = 32'hffffe92c;
    localparam logic [31:0] ADR_C2_CNT   = 32'hffffe930;
    localparam logic [31:0] ADR_C2_MATCH = 32'hffffe934;
    localparam logic [31:0] ADR_C2_CTL   = 32'hffffe93c;

    // Reset values
    localparam logic [15:0] RST_PRESC = 16'h0000;
    localparam logic [15:0] RST_CNT   = 16'h0000;
    localparam logic [15:0] RST_MATCH = 16'hffff;
    localparam logic [15:0] RST_PW    = 16'h0000;
    localparam logic [15:0] RST_CTL   = 16'h0000;

    // Control bits that software may store; reserved 8:4 drop out
    localparam logic [15:0] CTL_WR_MASK = 16'hfe0f;

    // Control register layout, bit 15 first
    typedef struct packed {
        logic       lock;                // Control write lock
        logic       value_write_lock;    // Count and match write lock
        logic       ack_by_match_write;  // 1: hold output until match write
        logic       route_out;           // Drive output onto shared_io_pin
        logic       gate_pin_enable;     // Honour gate pin
        logic       bus_watchdog_enable; // Clear count on bus cycle start
        logic       run_control;         // 0 counts, 1 stops
        logic [4:0] rsvd;                // Reads as zero
        logic [3:0] psel;                // Prescaler tap
    } tmr_ctl_s;

    // Terminal-count output state
    typedef enum logic [1:0] {
        TC_HIGH = 2'b01,
        TC_LOW  = 2'b10
    } tmr_tc_e;

endpackage

//--- src/tmr_channel.sv
// One timer channel: 16-bit count, match detect, gate and bus clear.
// Assumes tick and gate level arrive already in the clk_in domain.
module tmr_channel (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             tick_in,      // Selected prescaler tap
    input  wire logic             gate_n_in,    // Synchronised gate level
    input  wire logic             bus_start_in, // Start of external bus cycle
    input  wire tmr_pkg::tmr_ctl_s ctl_in,      // Channel control fields
    input  wire logic [15:0]      match_in,     // Match value
    input  wire logic             cnt_wr_in,    // Software count write
    input  wire logic [15:0]      wr_data_in,   // Count write data
    output logic      [15:0]      count_out,    // Present count
    output logic                  hit_out       // Count equals match on tick
);

    // Advance qualifier and next count
    logic        advance;    // Tick taken this cycle
    logic        gated;      // Gate pin holds the count
    logic        wr_ok;      // Count write accepted
    logic [15:0] next_count; // Next count value

    // Next count: write, then bus clear, then advance
    always_comb begin
        // Gate pin only matters when enabled
        gated = ctl_in.gate_pin_enable && gate_n_in;
        // Stop bit set means no counting
        advance = tick_in && !ctl_in.run_control && !gated;
        wr_ok = cnt_wr_in && !ctl_in.value_write_lock;
        hit_out = advance && (count_out == match_in);
        next_count = count_out;
        if (wr_ok) begin
            // Software value wins over counting
            next_count = wr_data_in;
        end else if (ctl_in.bus_watchdog_enable && bus_start_in) begin
            // Restart timeout window on every bus cycle
            next_count = tmr_pkg::RST_CNT;
        end else if (hit_out) begin
            // Restart from zero on match
            next_count = tmr_pkg::RST_CNT;
        end else if (advance) begin
            next_count = count_out + 16'h0001;
        end
    end

    // Count register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_out <= tmr_pkg::RST_CNT;
        end else begin
            count_out <= next_count;
        end
    end

endmodule

//--- src/tmr_top.sv
// Three-channel prescaled timer: register file, shared prescaler,
// gate pin synchronisers, terminal-count outputs and channel 0 pulse width.
// Assumes a single-cycle strobe bus master on clk_in (25 MHz) and
// asynchronous gate pins; bus_start_in comes from logic on clk_in.
//
// Chosen here: the plain strobed port.

// Contract
// - Prescaler free-runs from zero, wraps
// - Count resets zero, advances per tick
// - Enabled high gate holds count
// - Value lock blocks count and match writes
// - Match resets count, asserts terminal count
// - Ack mode holds output until match write
// - Auto mode releases after one clock
// - Channel 0 pulse width register, reset zero
// - Pulse width N releases after N+1 clocks
// - Match equals width minus one gives half duty; here match of twice width plus one does, and width minus one never rises
// - Control bit layout fixed
// - Control lock ignores later control writes
// - Select picks one of sixteen taps
// - Select n divides by two to n
// - Enable bit zero counts, one stops
// - Bus timeout clears count each bus cycle
// - Pin shows match one clock later
module tmr_top (
    input  wire logic        clk_in,               // System clock
    input  wire logic        rst_n_in,             // Asynchronous reset
    input  wire logic [31:0] addr_in,              // Byte address
    input  wire logic [31:0] wr_data_in,           // Write data
    input  wire logic        wr_in,                // Write strobe
    input  wire logic        rd_in,                // Read strobe
    input  wire logic [2:0]  gate_n_in,            // Gate pins, active low
    input  wire logic        bus_start_in,         // External bus cycle start
    output logic      [31:0] rd_data_out,          // Read data, next cycle
    output logic      [2:0]  terminal_count_n_out, // Output pins, active low
    output logic      [2:0]  tc_drive_en_out       // Pin drive enables
);

    // Channel count
    localparam int NCH = 3;

    // Address decode results
    logic          sel_presc;      // Prescaler
    logic          sel_rsvd;       // Internal pulse countdown
    logic          sel_pw;         // Channel 0 pulse width
    logic [NCH-1:0] sel_cnt;       // Channel counts
    logic [NCH-1:0] sel_match;     // Channel match values
    logic [NCH-1:0] sel_ctl;       // Channel controls

    // Decode on word index only; low two address bits are ignored so a
    // big-endian offset of two lands on the same register
    always_comb begin
        sel_presc    = addr_in[31:2] == tmr_pkg::ADR_PRESC[31:2];
        sel_rsvd     = addr_in[31:2] == tmr_pkg::ADR_RSVD[31:2];
        sel_pw       = addr_in[31:2] == tmr_pkg::ADR_C0_PW[31:2];
        sel_cnt[0]   = addr_in[31:2] == tmr_pkg::ADR_C0_CNT[31:2];
        sel_cnt[1]   = addr_in[31:2] == tmr_pkg::ADR_C1_CNT[31:2];
        sel_cnt[2]   = addr_in[31:2] == tmr_pkg::ADR_C2_CNT[31:2];
        sel_match[0] = addr_in[31:2] == tmr_pkg::ADR_C0_MATCH[31:2];
        sel_match[1] = addr_in[31:2] == tmr_pkg::ADR_C1_MATCH[31:2];
        sel_match[2] = addr_in[31:2] == tmr_pkg::ADR_C2_MATCH[31:2];
        sel_ctl[0]   = addr_in[31:2] == tmr_pkg::ADR_C0_CTL[31:2];
        sel_ctl[1]   = addr_in[31:2] == tmr_pkg::ADR_C1_CTL[31:2];
        sel_ctl[2]   = addr_in[31:2] == tmr_pkg::ADR_C2_CTL[31:2];
    end

    // Low half of the write data is all that any register holds
    logic [15:0] wdata;
    assign wdata = wr_data_in[15:0];


    // Shared prescaler

    logic [15:0] prescaler_counter;      // Free-running count
    logic [15:0] next_prescaler_counter; // Next count

    // Counts every clock and wraps; a write simply reloads it
    always_comb begin
        if (wr_in && sel_presc) begin
            next_prescaler_counter = wdata;
        end else begin
            next_prescaler_counter = prescaler_counter + 16'h0001;
        end
    end

    // Prescaler register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prescaler_counter <= tmr_pkg::RST_PRESC;
        end else begin
            prescaler_counter <= next_prescaler_counter;
        end
    end


    // Software registers

    tmr_pkg::tmr_ctl_s control [NCH];      // Per-channel control
    tmr_pkg::tmr_ctl_s next_control [NCH]; // Next control
    logic [15:0] match_value [NCH];        // Per-channel match value
    logic [15:0] next_match_value [NCH];   // Next match value
    logic [15:0] pulse_width;              // Channel 0 pulse width
    logic [15:0] next_pulse_width;         // Next pulse width
    logic [NCH-1:0] match_wr;              // Accepted match writes

    // Next register values from bus writes
    always_comb begin
        next_pulse_width = pulse_width;
        if (wr_in && sel_pw) begin
            next_pulse_width = wdata;
        end
        for (int i = 0; i < NCH; i++) begin
            next_control[i] = control[i];
            next_match_value[i] = match_value[i];
            // Lock blocks match writes as it does count writes
            match_wr[i] = wr_in && sel_match[i] && !control[i].value_write_lock;
            if (match_wr[i]) begin
                next_match_value[i] = wdata;
            end
            // Once locked, control cannot be changed until reset
            if (wr_in && sel_ctl[i] && !control[i].lock) begin
                // Reserved bits never stored, read back zero
                next_control[i] = tmr_pkg::tmr_ctl_s'(wdata & tmr_pkg::CTL_WR_MASK);
            end
        end
    end

    // Register file flops
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pulse_width <= tmr_pkg::RST_PW;
            for (int i = 0; i < NCH; i++) begin
                control[i] <= tmr_pkg::tmr_ctl_s'(tmr_pkg::RST_CTL);
                match_value[i] <= tmr_pkg::RST_MATCH;
            end
        end else begin
            pulse_width <= next_pulse_width;
            for (int i = 0; i < NCH; i++) begin
                control[i] <= next_control[i];
                match_value[i] <= next_match_value[i];
            end
        end
    end


    // Gate pin synchronisers

    logic [NCH-1:0] gate_s1;        // First stage, read by stage two only
    logic [NCH-1:0] gate_s2;        // Second stage
    logic [NCH-1:0] gate_s3;        // Third stage
    logic [NCH-1:0] gate_lvl;       // Accepted gate level
    logic [NCH-1:0] next_gate_lvl;  // Next accepted level

    // Level changes only once stages two and three agree, so a
    // metastable settle cannot produce a one-cycle glitch
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            next_gate_lvl[i] = (gate_s2[i] == gate_s3[i]) ? gate_s3[i] : gate_lvl[i];
        end
    end

    // Synchroniser flops; reset to high, the holding level
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gate_s1  <= 3'h7;
            gate_s2  <= 3'h7;
            gate_s3  <= 3'h7;
            gate_lvl <= 3'h7;
        end else begin
            gate_s1  <= gate_n_in;
            gate_s2  <= gate_s1;
            gate_s3  <= gate_s2;
            gate_lvl <= next_gate_lvl;
        end
    end


    // Tap selection and channels

    logic [NCH-1:0] tick;        // Selected tap fires
    logic [15:0]    tap_mask;    // Low bits that must be all ones
    logic [15:0]    count [NCH]; // Channel counts
    logic [NCH-1:0] hit;         // Match reached on a tick

    // Tap n fires once every 2**n clocks: when the low n prescaler
    // bits are all ones; n = 0 gives an empty mask, every clock
    always_comb begin
        tap_mask = 16'h0000;
        for (int i = 0; i < NCH; i++) begin
            tap_mask = 16'((17'h00001 << control[i].psel) - 17'h00001);
            tick[i] = (prescaler_counter & tap_mask) == tap_mask;
        end
    end

    // One counting channel per timer
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        tmr_channel u_ch (
            .clk_in       (clk_in),
            .rst_n_in     (rst_n_in),
            .tick_in      (tick[g]),
            .gate_n_in    (gate_lvl[g]),
            .bus_start_in (bus_start_in),
            .ctl_in       (control[g]),
            .match_in     (match_value[g]),
            .cnt_wr_in    (wr_in && sel_cnt[g]),
            .wr_data_in   (wdata),
            .count_out    (count[g]),
            .hit_out      (hit[g])
        );
    end


    // Terminal-count state

    tmr_pkg::tmr_tc_e tc_st [NCH];      // Output state per channel
    tmr_pkg::tmr_tc_e next_tc_st [NCH]; // Next output state
    logic [15:0] pw_left;               // Channel 0 ticks still low
    logic [15:0] next_pw_left;          // Next countdown
    logic [NCH-1:0] next_tc_n;          // Next pin level

    // Output drops on a hit; release depends on mode. A hit in the same
    // cycle as an acknowledging write keeps the output low.
    always_comb begin
        next_pw_left = pw_left;
        for (int i = 0; i < NCH; i++) begin
            next_tc_st[i] = tc_st[i];
            unique case (tc_st[i])
                tmr_pkg::TC_HIGH: begin
                    if (hit[i]) begin
                        next_tc_st[i] = tmr_pkg::TC_LOW;
                    end
                end
                tmr_pkg::TC_LOW: begin
                    if (control[i].ack_by_match_write) begin
                        // Only a match write releases, set wins
                        if (match_wr[i] && !hit[i]) begin
                            next_tc_st[i] = tmr_pkg::TC_HIGH;
                        end
                    end else if (i == 0) begin
                        // Countdown expired and no fresh hit
                        if (!hit[i] && pw_left == 16'h0000) begin
                            next_tc_st[i] = tmr_pkg::TC_HIGH;
                        end
                    end else if (!hit[i]) begin
                        next_tc_st[i] = tmr_pkg::TC_HIGH;
                    end
                end
                default: begin
                    // Illegal code recovers to released
                    next_tc_st[i] = tmr_pkg::TC_HIGH;
                end
            endcase
            next_tc_n[i] = next_tc_st[i] != tmr_pkg::TC_LOW;
        end
        // Load width on hit; a width past the match period reloads before
        // expiry, so the output never rises
        if (hit[0]) begin
            next_pw_left = pulse_width;
        end else if (tc_st[0] == tmr_pkg::TC_LOW && tick[0] && pw_left != 16'h0000) begin
            next_pw_left = pw_left - 16'h0001;
        end
    end

    // State and pin flops; pin takes the same next value as the state
    // so it trails the match cycle by exactly one clock
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pw_left <= 16'h0000;
            terminal_count_n_out <= 3'h7;
            tc_drive_en_out <= 3'h0;
            for (int i = 0; i < NCH; i++) begin
                tc_st[i] <= tmr_pkg::TC_HIGH;
            end
        end else begin
            pw_left <= next_pw_left;
            terminal_count_n_out <= next_tc_n;
            for (int i = 0; i < NCH; i++) begin
                tc_st[i] <= next_tc_st[i];
                tc_drive_en_out[i] <= next_control[i].route_out;
            end
        end
    end


    // Read path

    logic [15:0] rd_val;       // Selected register
    logic [31:0] next_rd_data; // Next bus read data

    // Mux selected register; unmapped words read zero. The reserved
    // word shows the pulse countdown, for debug only.
    always_comb begin
        rd_val = 16'h0000;
        if (sel_presc) begin
            rd_val = prescaler_counter;
        end else if (sel_rsvd) begin
            rd_val = pw_left;
        end else if (sel_pw) begin
            rd_val = pulse_width;
        end
        for (int i = 0; i < NCH; i++) begin
            if (sel_cnt[i]) begin
                rd_val = count[i];
            end
            if (sel_match[i]) begin
                rd_val = match_value[i];
            end
            if (sel_ctl[i]) begin
                rd_val = 16'(control[i]);
            end
        end
        // Data stands only in the cycle after the strobe
        next_rd_data = rd_in ? {16'h0000, rd_val} : 32'h00000000;
    end

    // Read data flop
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out <= 32'h00000000;
        end else begin
            rd_data_out <= next_rd_data;
        end
    end

endmodule

//--- verification/tmr_checker.sv
// Port assertions for the three-channel timer, bound to tmr_top.
// Assumes software reaches registers only through the strobe bus.
module tmr_checker (
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [2:0]  gate_n_in,
    input wire logic        bus_start_in,
    input wire logic [31:0] rd_data_out,
    input wire logic [2:0]  terminal_count_n_out,
    input wire logic [2:0]  tc_drive_en_out
);
    logic [15:0] ctl_sh [3]; // Stored control words
    logic [15:0] mat_sh [3]; // Stored match values
    logic [15:0] presc_sh;   // Prescaler shadow
    logic        presc_ok;   // Shadow trusted only after a write
    // Word decode, low address bits ignored
    function automatic logic hit(input logic [31:0] a);
        return addr_in[31:2] == a[31:2];
    endfunction
    function automatic logic [31:0] base(input int c);
        return tmr_pkg::ADR_C0_CNT + 32'(16 * c);
    endfunction
    // Shadows obey the same locks as the device
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            presc_sh <= 16'h0;
            presc_ok <= 1'b0;
            ctl_sh   <= '{3{16'h0}};
            mat_sh   <= '{3{16'hffff}};
        end else begin
            presc_ok <= presc_ok | (wr_in && hit(tmr_pkg::ADR_PRESC));
            presc_sh <= (wr_in && hit(tmr_pkg::ADR_PRESC)) ? wr_data_in[15:0] : presc_sh + 16'h1;
            for (int c = 0; c < 3; c++) begin
                if (wr_in && hit(base(c) + 32'hc) && !ctl_sh[c][15])
                    ctl_sh[c] <= wr_data_in[15:0] & tmr_pkg::CTL_WR_MASK;
                if (wr_in && hit(base(c) + 32'h4) && !ctl_sh[c][14])
                    mat_sh[c] <= wr_data_in[15:0];
            end
        end
    end
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    a_rd_idle: assert property (!$past(rd_in) |-> rd_data_out == 32'h0)
        else $error("read data not idle");
    a_presc_track: assert property (rd_in && presc_ok && hit(tmr_pkg::ADR_PRESC)
        |=> rd_data_out[15:0] == $past(presc_sh)) else $error("prescaler value wrong");
    a_match_track: assert property (rd_in && hit(base(2) + 32'h4)
        |=> rd_data_out[15:0] == $past(mat_sh[2])) else $error("match value wrong");
    a_rsvd_zero: assert property (rd_in && hit(base(2) + 32'hc)
        |=> rd_data_out[8:4] == 5'h0) else $error("reserved bits not zero");
    a_route_follow: assert property ($changed(ctl_sh[1][12])
        |-> ##[0:1] tc_drive_en_out[1] == ctl_sh[1][12]) else $error("route bit not followed");
    a_drive_locked: assert property (ctl_sh[2][15] && $past(ctl_sh[2][15])
        |-> tc_drive_en_out[2] == ctl_sh[2][12]) else $error("locked control changed");
    a_ack_hold: assert property (ctl_sh[2][13] && !terminal_count_n_out[2] && !wr_in
        |=> !terminal_count_n_out[2]) else $error("acknowledged output released early");
    a_auto_pulse: assert property (!ctl_sh[1][13] && mat_sh[1] != 16'h0 && !$past(wr_in)
        && $fell(terminal_count_n_out[1]) |=> terminal_count_n_out[1]) else $error("pulse too long");
    c_pulse: cover property ($fell(terminal_count_n_out[1]));
    c_locked: cover property (ctl_sh[2][15]);
    c_presc: cover property (rd_in && presc_ok && hit(tmr_pkg::ADR_PRESC));
endmodule

bind tmr_top tmr_checker i_tmr_checker (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .gate_n_in(gate_n_in), .bus_start_in(bus_start_in), .rd_data_out(rd_data_out),
    .terminal_count_n_out(terminal_count_n_out), .tc_drive_en_out(tc_drive_en_out));

//--- verification/tmr_pin_model.sv
// Far side of the timer: gate sources and terminal-count pin loads.
// Assumes the bench asks for gate levels; undriven pins are pulled up.
module tmr_pin_model (
    input  wire logic       clk_in,      // System clock
    input  wire logic [2:0] gate_req_in, // Wanted gate levels
    input  wire logic [2:0] tc_n_in,     // Timer outputs
    input  wire logic [2:0] tc_en_in,    // Timer drive enables
    output logic      [2:0] gate_n_out,  // Gate pins, active low
    output logic      [2:0] pin_out      // Level on each wire
);
    // Gate moves well off the sampling edge, like an unrelated source
    initial gate_n_out = 3'h0;
    always @(posedge clk_in) gate_n_out <= #13 gate_req_in;
    // Released pin floats to its pull-up, never to the last value
    assign pin_out = (tc_en_in & tc_n_in) | ~tc_en_in;
endmodule

//--- verification/testbench.sv
// Self-checking bench for tmr_top with the pin model on its far side.
// Assumes the package constants and a 25 MHz clock.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // Register case: address, data, write first, expected read
    typedef struct packed {
        logic [31:0] a;
        logic [31:0] d;
        logic        w;
        logic [15:0] e;
    } tmr_row_s;
    localparam tmr_row_s ROWS [8] = '{
        '{tmr_pkg::ADR_C0_MATCH, 32'h0, 1'b0, 16'hffff},
        '{tmr_pkg::ADR_C2_MATCH, 32'h0, 1'b0, 16'hffff},
        '{tmr_pkg::ADR_C0_PW, 32'h0, 1'b0, 16'h0},
        '{tmr_pkg::ADR_C2_CTL, 32'h0, 1'b0, 16'h0},
        '{32'hffffe908, 32'h1234, 1'b1, 16'h0},
        '{tmr_pkg::ADR_C0_PW, 32'habcd1234, 1'b1, 16'h1234},
        '{tmr_pkg::ADR_C0_PW + 32'h2, 32'h0, 1'b0, 16'h1234},
        '{tmr_pkg::ADR_C1_CTL, 32'h1000, 1'b1, 16'h1000}
    };
    // Channel 2 runs: control, gate level, counts gained in 80 clocks
    localparam logic [15:0] CT_CTL [7] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h200, 16'h800, 16'h800};
    localparam logic        CT_GATE [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    localparam int          CT_EXP [7] = '{80, 40, 20, 10, 0, 0, 80};
    localparam int          PWS [3] = '{0, 1, 3}; // Pulse widths tried
    logic        clk_in;
    logic        rst_n_in;
    logic [31:0] addr_in;
    logic [31:0] wr_data_in;
    logic        wr_in;
    logic        rd_in;
    logic        bus_start_in;
    logic [2:0]  gate_req;
    logic [2:0]  gate_n;
    logic [31:0] rd_data;
    logic [2:0]  tc_n;
    logic [2:0]  tc_en;
    logic [2:0]  pin;
    logic [31:0] v;  // Last read value
    logic [31:0] v1; // Earlier read value
    int          miscompares;
    int          comparisons;
    tmr_top i_tmr_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .gate_n_in(gate_n),
        .bus_start_in(bus_start_in), .rd_data_out(rd_data), .terminal_count_n_out(tc_n),
        .tc_drive_en_out(tc_en));
    tmr_pin_model i_tmr_pin_model (.clk_in(clk_in), .gate_req_in(gate_req), .tc_n_in(tc_n),
        .tc_en_in(tc_en), .gate_n_out(gate_n), .pin_out(pin));
    function automatic logic [31:0] base(input int c);
        return tmr_pkg::ADR_C0_CNT + 32'(16 * c);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One strobe cycle; read data taken in the cycle after
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in    <= a;
        wr_data_in <= d;
        wr_in      <= w;
        rd_in      <= !w;
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        #1;
        v = rd_data;
    endtask
    // Park count above match, then time one pulse from a count of zero
    task automatic pulse(input int ch, input logic [15:0] m, input int lo);
        bus(1'b1, base(ch), 32'(m) + 32'h1);
        repeat (8) @(posedge clk_in);
        bus(1'b1, base(ch) + 32'h4, 32'(m));
        bus(1'b1, base(ch), 32'h0);
        for (int i = 1; i <= m + lo + 1; i++) begin
            @(posedge clk_in);
            #1;
            chk(32'(ch == 1 ? pin[1] : tc_n[ch]), 32'(!(i > m && i <= m + lo)));
        end
    endtask
    task automatic end_of_test();
        if (miscompares == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Free-running system clock
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    // Hang guard, far beyond the eight hundred or so clocks needed
    initial begin
        #800000;
        miscompares++;
        end_of_test();
    end
    initial begin
        rst_n_in     = 1'b0;
        addr_in      = 32'h0;
        wr_data_in   = 32'h0;
        wr_in        = 1'b0;
        rd_in        = 1'b0;
        bus_start_in = 1'b0;
        gate_req     = 3'h0;
        miscompares  = 0;
        comparisons  = 0;
        repeat (8) @(posedge clk_in);
        chk(32'({tc_en, tc_n}), 32'h7);
        chk(rd_data, 32'h0);
        rst_n_in <= 1'b1;
        foreach (ROWS[i]) begin
            if (ROWS[i].w)
                bus(1'b1, ROWS[i].a, ROWS[i].d);
            bus(1'b0, ROWS[i].a, 32'h0);
            chk(v, 32'(ROWS[i].e));
        end
        // Prescaler wraps through zero; address 904 is never touched
        bus(1'b1, tmr_pkg::ADR_PRESC, 32'hfffe);
        bus(1'b0, tmr_pkg::ADR_PRESC, 32'h0);
        chk(v, 32'hffff);
        bus(1'b0, tmr_pkg::ADR_PRESC, 32'h0);
        chk(v, 32'h1);
        pulse(1, 16'h5, 1);
        foreach (PWS[i]) begin
            bus(1'b1, tmr_pkg::ADR_C0_PW, 32'(PWS[i]));
            pulse(0, 16'h5, PWS[i] + 1);
        end
        // Taps, stop and gate, counted over a fixed window
        foreach (CT_CTL[i]) begin
            gate_req <= {CT_GATE[i], 2'b00};
            bus(1'b1, base(2) + 32'hc, 32'(CT_CTL[i]));
            repeat (4) @(posedge clk_in);
            bus(1'b0, base(2), 32'h0);
            v1 = v;
            repeat (78) @(posedge clk_in);
            bus(1'b0, base(2), 32'h0);
            chk(v - v1, 32'(CT_EXP[i]));
        end
        // Acknowledge mode holds the output until a match write
        bus(1'b1, base(2) + 32'hc, 32'h2000);
        bus(1'b1, base(2) + 32'h4, 32'h3);
        bus(1'b1, base(2), 32'h0);
        repeat (12) @(posedge clk_in);
        bus(1'b1, base(2) + 32'hc, 32'h2200);
        chk(32'(tc_n[2]), 32'h0);
        bus(1'b1, base(2) + 32'h4, 32'h100);
        @(posedge clk_in);
        #1;
        chk(32'(tc_n[2]), 32'h1);
        // Both locks at once, then writes that must be ignored
        bus(1'b1, base(2) + 32'hc, 32'hd200);
        bus(1'b1, base(2) + 32'h4, 32'h55);
        bus(1'b1, base(2) + 32'hc, 32'h0);
        bus(1'b0, base(2) + 32'h4, 32'h0);
        chk(v, 32'h100);
        bus(1'b0, base(2) + 32'hc, 32'h0);
        chk(v, 32'hd200);
        chk(32'(tc_en[2]), 32'h1);
        // Bus cycle start clears a watched count
        bus(1'b1, base(1) + 32'hc, 32'h040f);
        bus(1'b1, base(1), 32'h1234);
        bus_start_in <= 1'b1;
        @(posedge clk_in);
        bus_start_in <= 1'b0;
        bus(1'b0, base(1), 32'h0);
        chk(v, 32'h0);
        end_of_test();
    end
endmodule
